// *** design/gpb_pkg.sv ***
// Constants, register map and helpers for the parallel I/O bank.
// Assumes a 16-bit register file reached through a 32-bit AXI4-Lite slave.
package gpb_pkg;
  localparam int          DATA_W      = 16;
  localparam int          AXI_ADDR_W  = 18;
  localparam int          IDX_W       = 16;
  localparam int          NUM_PINS    = 32;
  localparam int          HIGH_EN_W   = 14;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_EN_LOW   = 16'h4400;
  localparam logic [15:0] IDX_DIR_LOW  = 16'h4401;
  localparam logic [15:0] IDX_DATA_LOW = 16'h4402;
  localparam logic [15:0] IDX_EN_MID   = 16'h4403;
  localparam logic [15:0] IDX_DIR_MID  = 16'h4404;
  localparam logic [15:0] IDX_DATA_MID = 16'h4405;
  localparam logic [15:0] IDX_EN_HIGH  = 16'h4406;
  localparam logic [15:0] RST_ENABLE    = 16'h0000;
  localparam logic [15:0] RST_DIRECTION = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [15:0] UPPER_ZERO  = 16'h0000;

  // Byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] gpb_merge(
    input logic [15:0] cur,
    input logic [15:0] wval,
    input logic [1:0]  strb);
    logic [15:0] mask;
    mask = {{8{strb[1]}}, {8{strb[0]}}};
    return (cur & ~mask) | (wval & mask);
  endfunction
endpackage

// *** design/gpb_wr_if.sv ***
// Write port shared by the register slices of the I/O bank.
// Assumes one source drives data and byte strobes for all slices.
`timescale 1ns/1ns
interface gpb_wr_if;
  logic [15:0] data;
  logic [1:0]  strb;
  modport src  (output data, output strb);
  modport bank (input data, input strb);
endinterface

// *** design/gpb_pin_cell.sv ***
// One shared pin: input synchroniser and registered output driver.
// Assumes the pad resolves the wire from pin_out and pin_oe_n.
`timescale 1ns/1ns
module gpb_pin_cell (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin_in,
  input  wire logic enable,
  input  wire logic direction,
  input  wire logic drive_level,
  input  wire logic bus_owned,
  output logic      level,
  output logic      pin_out,
  output logic      pin_oe_n
);
  logic meta_reg;
  logic level_reg;
  logic drive_on;

  // Drive only when enabled, an output, and not owned by the bus
  assign drive_on = enable & direction & ~bus_owned;
  assign level    = level_reg;

  // Data path only; follows the pin during reset as well
  always_ff @(posedge aclk) begin
    meta_reg  <= pin_in;
    level_reg <= meta_reg;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out  <= drive_level;
      pin_oe_n <= ~drive_on;
    end
  end
endmodule

// *** design/gpb_reg16.sv ***
// 16-bit read/write control register slice with byte strobes.
// Assumes sel is a one-cycle write commit from the bus slave.
`timescale 1ns/1ns
module gpb_reg16
  import gpb_pkg::*;
#(
  parameter logic [15:0] RESET_VALUE = 16'h0000
) (
  input  wire logic  aclk,
  input  wire logic  aresetn,
  gpb_wr_if.bank     wr,
  input  wire logic  sel,
  output logic [15:0] q
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= RESET_VALUE;
    end else if (sel) begin
      q <= gpb_merge(q, wr.data, wr.strb);
    end
  end
endmodule

// *** design/gpb_parallel_gpio_bank.sv ***
// Top of the parallel I/O bank: AXI4-Lite slave, register file, pin cells.
// Assumes bus_owned comes from logic on aclk; pin_in is asynchronous.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ns
// How it works
// - Input pin: data bit reads 0 for low pin, 1 for high pin.
// - Output pin: written data bit 0 drives low, 1 drives high.
// - Enable bit 0: function off, pin left undriven.
// - Enable bit 1: pin follows its direction and data bits.
// - Direction 0 makes the pin an input, 1 an output.
// - Enable and direction bits read back, writable, reset to 0.
// - After reset each data bit holds its pin's level.
// - Low data register bits 0-15 map to pins 0-15.
// - Mid registers bits 0-15 map to pins 16-31.
// - A pin owned by memory or host port is never taken by enable.
module gpb_parallel_gpio_bank
  import gpb_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [NUM_PINS-1:0]   pin_in,
  input  wire logic [NUM_PINS-1:0]   bus_owned,
  output logic [NUM_PINS-1:0]        pin_out,
  output logic [NUM_PINS-1:0]        pin_oe_n,
  output logic [HIGH_EN_W-1:0]       high_pin_enable
);
  // Write channel state
  logic                  aw_held_reg;
  logic                  aw_held_next;
  logic [AXI_ADDR_W-1:0] aw_addr_reg;
  logic                  w_held_reg;
  logic                  w_held_next;
  logic [15:0]           w_data_reg;
  logic [1:0]            w_strb_reg;
  logic                  awready_reg;
  logic                  awready_next;
  logic                  wready_reg;
  logic                  wready_next;
  logic                  bvalid_reg;
  logic                  bvalid_next;
  logic [1:0]            bresp_reg;
  // Read channel state
  logic                  ar_held_reg;
  logic                  ar_held_next;
  logic [AXI_ADDR_W-1:0] ar_addr_reg;
  logic                  arready_reg;
  logic                  arready_next;
  logic                  rvalid_reg;
  logic                  rvalid_next;
  logic [15:0]           rdata_reg;
  logic [1:0]            rresp_reg;
  // Handshakes and decode
  logic                  aw_fire;
  logic                  w_fire;
  logic                  ar_fire;
  logic                  wr_commit;
  logic                  rd_commit;
  logic [IDX_W-1:0]      wr_idx;
  logic [IDX_W-1:0]      rd_idx;
  logic                  wr_mapped;
  logic                  rd_mapped;
  logic [15:0]           rd_value;
  // Register file
  logic [15:0]           en_low;
  logic [15:0]           dir_low;
  logic [15:0]           en_mid;
  logic [15:0]           dir_mid;
  logic [15:0]           en_high;
  logic [15:0]           data_low_reg;
  logic [15:0]           data_low_next;
  logic [15:0]           data_mid_reg;
  logic [15:0]           data_mid_next;
  logic [15:0]           data_low_view;
  logic [15:0]           data_mid_view;
  logic [NUM_PINS-1:0]   level;
  logic [NUM_PINS-1:0]   en_all;
  logic [NUM_PINS-1:0]   dir_all;
  logic [NUM_PINS-1:0]   data_all;
  logic                  sel_en_low;
  logic                  sel_dir_low;
  logic                  sel_data_low;
  logic                  sel_en_mid;
  logic                  sel_dir_mid;
  logic                  sel_data_mid;
  logic                  sel_en_high;

  gpb_wr_if wr_bus ();

  function automatic logic gpb_hit(
    input logic [IDX_W-1:0] idx,
    input logic [IDX_W-1:0] target);
    return idx == target;
  endfunction

  // Input bits mirror the pin; output bits keep what software wrote
  function automatic logic [15:0] gpb_data_next(
    input logic [15:0] cur,
    input logic [15:0] wval,
    input logic [1:0]  strb,
    input logic        sel,
    input logic [15:0] dir,
    input logic [15:0] pin_level);
    logic [15:0] stored;
    stored = sel ? gpb_merge(cur, wval, strb) : cur;
    return (stored & dir) | (pin_level & ~dir);
  endfunction

  // AXI handshakes
  assign aw_fire   = s_axi_awvalid & awready_reg;
  assign w_fire    = s_axi_wvalid & wready_reg;
  assign ar_fire   = s_axi_arvalid & arready_reg;
  assign wr_commit = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign rd_commit = ar_held_reg;

  assign aw_held_next = aw_fire | (aw_held_reg & ~wr_commit);
  assign w_held_next  = w_fire | (w_held_reg & ~wr_commit);
  assign bvalid_next  = wr_commit | (bvalid_reg & ~s_axi_bready);
  assign awready_next = ~aw_held_next & ~bvalid_next;
  assign wready_next  = ~w_held_next & ~bvalid_next;
  assign ar_held_next = ar_fire | (ar_held_reg & ~rd_commit);
  assign rvalid_next  = rd_commit | (rvalid_reg & ~s_axi_rready);
  assign arready_next = ~ar_held_next & ~rvalid_next;

  // Address decode
  assign wr_idx = aw_addr_reg[AXI_ADDR_W-1:2];
  assign rd_idx = ar_addr_reg[AXI_ADDR_W-1:2];

  assign sel_en_low   = wr_commit & gpb_hit(wr_idx, IDX_EN_LOW);
  assign sel_dir_low  = wr_commit & gpb_hit(wr_idx, IDX_DIR_LOW);
  assign sel_data_low = wr_commit & gpb_hit(wr_idx, IDX_DATA_LOW);
  assign sel_en_mid   = wr_commit & gpb_hit(wr_idx, IDX_EN_MID);
  assign sel_dir_mid  = wr_commit & gpb_hit(wr_idx, IDX_DIR_MID);
  assign sel_data_mid = wr_commit & gpb_hit(wr_idx, IDX_DATA_MID);
  assign sel_en_high  = wr_commit & gpb_hit(wr_idx, IDX_EN_HIGH);

  assign wr_mapped = gpb_hit(wr_idx, IDX_EN_LOW)
                   | gpb_hit(wr_idx, IDX_DIR_LOW)
                   | gpb_hit(wr_idx, IDX_DATA_LOW)
                   | gpb_hit(wr_idx, IDX_EN_MID)
                   | gpb_hit(wr_idx, IDX_DIR_MID)
                   | gpb_hit(wr_idx, IDX_DATA_MID)
                   | gpb_hit(wr_idx, IDX_EN_HIGH);

  assign rd_mapped = gpb_hit(rd_idx, IDX_EN_LOW)
                   | gpb_hit(rd_idx, IDX_DIR_LOW)
                   | gpb_hit(rd_idx, IDX_DATA_LOW)
                   | gpb_hit(rd_idx, IDX_EN_MID)
                   | gpb_hit(rd_idx, IDX_DIR_MID)
                   | gpb_hit(rd_idx, IDX_DATA_MID)
                   | gpb_hit(rd_idx, IDX_EN_HIGH);

  // Data bits seen by software: pin level for inputs
  assign data_low_view = (data_low_reg & dir_low)
                       | (level[15:0] & ~dir_low);
  assign data_mid_view = (data_mid_reg & dir_mid)
                       | (level[31:16] & ~dir_mid);

  assign rd_value =
    gpb_hit(rd_idx, IDX_EN_LOW)   ? en_low        :
    gpb_hit(rd_idx, IDX_DIR_LOW)  ? dir_low       :
    gpb_hit(rd_idx, IDX_DATA_LOW) ? data_low_view :
    gpb_hit(rd_idx, IDX_EN_MID)   ? en_mid        :
    gpb_hit(rd_idx, IDX_DIR_MID)  ? dir_mid       :
    gpb_hit(rd_idx, IDX_DATA_MID) ? data_mid_view :
    gpb_hit(rd_idx, IDX_EN_HIGH)  ? en_high       : UPPER_ZERO;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      if (wr_commit) begin
        bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (aw_fire) begin
      aw_addr_reg <= s_axi_awaddr;
    end
    if (w_fire) begin
      w_data_reg <= s_axi_wdata[15:0];
      w_strb_reg <= s_axi_wstrb[1:0];
    end
    if (ar_fire) begin
      ar_addr_reg <= s_axi_araddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_held_reg <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= UPPER_ZERO;
      rresp_reg   <= RESP_OKAY;
    end else begin
      ar_held_reg <= ar_held_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      if (rd_commit) begin
        rdata_reg <= rd_value;
        rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = {UPPER_ZERO, rdata_reg};

  // Control register slices
  assign wr_bus.data = w_data_reg;
  assign wr_bus.strb = w_strb_reg;

  gpb_reg16 #(.RESET_VALUE(RST_ENABLE)) u_en_low (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr      (wr_bus),
    .sel     (sel_en_low),
    .q       (en_low)
  );
  gpb_reg16 #(.RESET_VALUE(RST_DIRECTION)) u_dir_low (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr      (wr_bus),
    .sel     (sel_dir_low),
    .q       (dir_low)
  );
  gpb_reg16 #(.RESET_VALUE(RST_ENABLE)) u_en_mid (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr      (wr_bus),
    .sel     (sel_en_mid),
    .q       (en_mid)
  );
  gpb_reg16 #(.RESET_VALUE(RST_DIRECTION)) u_dir_mid (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr      (wr_bus),
    .sel     (sel_dir_mid),
    .q       (dir_mid)
  );
  gpb_reg16 #(.RESET_VALUE(RST_ENABLE)) u_en_high (
    .aclk    (aclk),
    .aresetn (aresetn),
    .wr      (wr_bus),
    .sel     (sel_en_high),
    .q       (en_high)
  );

  assign high_pin_enable = en_high[HIGH_EN_W-1:0];

  // Data registers take the pin level while in reset
  assign data_low_next = gpb_data_next(data_low_reg, w_data_reg, w_strb_reg,
                                       sel_data_low, dir_low, level[15:0]);
  assign data_mid_next = gpb_data_next(data_mid_reg, w_data_reg, w_strb_reg,
                                       sel_data_mid, dir_mid, level[31:16]);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_low_reg <= level[15:0];
      data_mid_reg <= level[31:16];
    end else begin
      data_low_reg <= data_low_next;
      data_mid_reg <= data_mid_next;
    end
  end

  // Pin cells: low registers feed pins 0-15, mid registers 16-31
  assign en_all   = {en_mid, en_low};
  assign dir_all  = {dir_mid, dir_low};
  assign data_all = {data_mid_reg, data_low_reg};

  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    gpb_pin_cell u_cell (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .pin_in      (pin_in[i]),
      .enable      (en_all[i]),
      .direction   (dir_all[i]),
      .drive_level (data_all[i]),
      .bus_owned   (bus_owned[i]),
      .level       (level[i]),
      .pin_out     (pin_out[i]),
      .pin_oe_n    (pin_oe_n[i])
    );
  end

  // Checks
  sequence s_read_low_input;
    ar_fire && gpb_hit(s_axi_araddr[AXI_ADDR_W-1:2], IDX_DATA_LOW)
      && dir_low == 16'h0000 ##1 dir_low == 16'h0000;
  endsequence

  sequence s_write_low_driven;
    sel_data_low && w_strb_reg[0] && en_low[0] && dir_low[0]
      && !bus_owned[0] ##1 en_low[0] && dir_low[0] && !bus_owned[0];
  endsequence

  AST_READ_INPUT_LEVEL: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_read_low_input |=> s_axi_rvalid && s_axi_rdata[15:0] == $past(level[15:0]))
    else $error("input read did not return pin level");

  AST_WRITE_DRIVES_PIN: assert property (
    @(posedge aclk) disable iff (!aresetn)
    s_write_low_driven |=> pin_out[0] == $past(w_data_reg[0], 2)
      && !pin_oe_n[0])
    else $error("written level not driven on output pin");

  AST_DISABLED_FLOATS: assert property (
    @(posedge aclk) disable iff (!aresetn)
    !en_all[0] |=> pin_oe_n[0])
    else $error("disabled pin is driven");

  AST_ENABLED_FOLLOWS: assert property (
    @(posedge aclk) disable iff (!aresetn)
    en_all[16] && dir_all[16] && !bus_owned[16]
      |=> !pin_oe_n[16] && pin_out[16] == $past(data_all[16]))
    else $error("enabled output pin not following data bit");

  AST_INPUT_NOT_DRIVEN: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (dir_all != {NUM_PINS{1'b1}}) |=> (~pin_oe_n & ~$past(dir_all)) == '0)
    else $error("input pin is driven");

  AST_RESET_CLEARS: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> en_low == RST_ENABLE && dir_low == RST_DIRECTION
      && en_mid == RST_ENABLE && dir_mid == RST_DIRECTION
      && en_high == RST_ENABLE && pin_oe_n == {NUM_PINS{1'b1}})
    else $error("control bits not cleared by reset");

  AST_RESET_DATA_PIN: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> data_low_reg == $past(level[15:0])
      && data_mid_reg == $past(level[31:16]))
    else $error("data bits did not take pin level at reset");

  AST_LOW_MAP: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (&en_low) && (&dir_low) && !(|bus_owned[15:0])
      |=> pin_out[15:0] == $past(data_low_reg) && pin_oe_n[15:0] == '0)
    else $error("low register not mapped onto pins 0-15");

  AST_MID_MAP: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (&en_mid) && (&dir_mid) && !(|bus_owned[31:16])
      |=> pin_out[31:16] == $past(data_mid_reg) && pin_oe_n[31:16] == '0)
    else $error("mid registers not mapped onto pins 16-31");

  AST_BUS_OWNED_KEPT: assert property (
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> (~pin_oe_n & $past(bus_owned)) == '0)
    else $error("pin taken from bus owner");

  AST_DRIVER_GATED: assert property (
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> pin_oe_n == ~$past(en_all & dir_all & ~bus_owned))
    else $error("driver enable not equal to enable and direction");

  AST_WRITE_RESPONSE: assert property (
    @(posedge aclk) disable iff (!aresetn)
    wr_commit |=> s_axi_bvalid
      && s_axi_bresp == ($past(wr_mapped) ? RESP_OKAY : RESP_SLVERR))
    else $error("write response missing or wrong");
endmodule

// *** verif/gpb_pin_partner.sv ***
// Model of the external pads and the party sharing them with the bank.
// Assumes the bench says which pins the far side drives and to what level.
`timescale 1ns/1ns
module gpb_pin_partner
  import gpb_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic [NUM_PINS-1:0] pin_out,
  input  wire logic [NUM_PINS-1:0] pin_oe_n,
  input  wire logic [NUM_PINS-1:0] ext_en,
  input  wire logic [NUM_PINS-1:0] ext_level,
  output logic      [NUM_PINS-1:0] pin_in
);
  logic [NUM_PINS-1:0] float_reg;

  // An undriven pad has no pull, so it wanders instead of keeping a level
  initial float_reg = '0;
  always @(posedge aclk) begin
    float_reg <= ~pin_in;
  end

  // The bank's driver wins, then the far side, else the pad floats
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];
      end else if (ext_en[i]) begin
        pin_in[i] = ext_level[i];
      end else begin
        pin_in[i] = float_reg[i];
      end
    end
  end
endmodule

// *** verif/gpb_parallel_gpio_bank_bench.sv ***
// Self-checking bench for the parallel I/O bank over AXI4-Lite.
// Assumes the pin partner model stands on the pad side of the bank.
`timescale 1ns/1ns
module gpb_parallel_gpio_bank_bench
  import gpb_pkg::*;
;
  logic                  aclk, aresetn;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp, resp;
  logic [NUM_PINS-1:0]   pin_in, pin_out, pin_oe_n, bus_owned;
  logic [NUM_PINS-1:0]   ext_en, ext_level;
  logic [HIGH_EN_W-1:0]  high_pin_enable;
  logic [31:0]           rd_val;
  int                    fail_count, checks, cycles;

  gpb_parallel_gpio_bank dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pin_in(pin_in), .bus_owned(bus_owned),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .high_pin_enable(high_pin_enable)
  );

  gpb_pin_partner pads_u (
    .aclk(aclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_en(ext_en),
    .ext_level(ext_level), .pin_in(pin_in)
  );

  task automatic end_sim;
    if (fail_count == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Address and data are offered together, each dropped when taken
  task automatic wr(input logic [15:0] idx, input logic [15:0] val,
                    input logic [3:0] strb, input logic [1:0] exp_resp);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= {idx, 2'h0};
    wdata <= {16'h0000, val};
    wstrb <= strb;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    chk("bresp", {30'h0, exp_resp}, {30'h0, resp});
  endtask

  task automatic rd(input logic [15:0] idx, input logic [1:0] exp_resp,
                    input logic [31:0] exp);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd_val = rdata;
    resp = rresp;
    rready <= 1'b0;
    chk("rresp", {30'h0, exp_resp}, {30'h0, resp});
    chk("rdata", exp, rd_val);
  endtask

  task automatic t_reset;
    chk("oe_n after reset", 32'hFFFFFFFF, pin_oe_n);
    chk("high enables", 32'h0, {18'h0, high_pin_enable});
    rd(IDX_EN_MID, RESP_OKAY, 32'h0);
    rd(IDX_DIR_MID, RESP_OKAY, 32'h0);
    rd(IDX_EN_HIGH, RESP_OKAY, 32'h0);
    rd(IDX_DATA_LOW, RESP_OKAY, 32'h0000A5C3);
    rd(IDX_DATA_MID, RESP_OKAY, 32'h00003C96);
  endtask

  task automatic t_regs;
    wr(IDX_EN_MID, 16'h5AF0, 4'hF, RESP_OKAY);
    rd(IDX_EN_MID, RESP_OKAY, 32'h00005AF0);
    wr(IDX_EN_MID, 16'hFFFF, 4'h2, RESP_OKAY);
    rd(IDX_EN_MID, RESP_OKAY, 32'h0000FFF0);
    wr(IDX_DIR_MID, 16'hA50F, 4'hF, RESP_OKAY);
    rd(IDX_DIR_MID, RESP_OKAY, 32'h0000A50F);
    wr(IDX_EN_HIGH, 16'hE5A9, 4'hF, RESP_OKAY);
    rd(IDX_EN_HIGH, RESP_OKAY, 32'h0000E5A9);
    chk("high enables", 32'h25A9, {18'h0, high_pin_enable});
    repeat (2) @(posedge aclk);
    chk("mid oe_n", 32'h5AFF, {16'h0, pin_oe_n[31:16]});
    wr(IDX_EN_MID, 16'h0000, 4'hF, RESP_OKAY);
    wr(IDX_DIR_MID, 16'h0000, 4'hF, RESP_OKAY);
  endtask

  task automatic t_input;
    wr(IDX_EN_MID, 16'hFFFF, 4'hF, RESP_OKAY);
    ext_level[31:16] <= 16'h6A1E;
    repeat (4) @(posedge aclk);
    rd(IDX_DATA_MID, RESP_OKAY, 32'h00006A1E);
    chk("input oe_n", 32'hFFFF, {16'h0, pin_oe_n[31:16]});
    ext_level[31:16] <= 16'h95E1;
    repeat (4) @(posedge aclk);
    rd(IDX_DATA_MID, RESP_OKAY, 32'h000095E1);
  endtask

  task automatic t_output;
    ext_en[31:16] <= 16'h0000;
    wr(IDX_DIR_MID, 16'hFFFF, 4'hF, RESP_OKAY);
    wr(IDX_EN_MID, 16'h00FF, 4'hF, RESP_OKAY);
    wr(IDX_DATA_MID, 16'hC3A5, 4'hF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("mid oe_n", 32'hFF00, {16'h0, pin_oe_n[31:16]});
    chk("mid out", 32'hC3A5, {16'h0, pin_out[31:16]});
    rd(IDX_DATA_MID, RESP_OKAY, 32'h0000C3A5);
    bus_owned[23:16] <= 8'hFF;
    repeat (2) @(posedge aclk);
    chk("owned oe_n", 32'hFFFF, {16'h0, pin_oe_n[31:16]});
    bus_owned <= '0;
    wr(IDX_DATA_MID, 16'h3C5A, 4'hF, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("mid out", 32'h3C5A, {16'h0, pin_out[31:16]});
    chk("mid oe_n", 32'hFF00, {16'h0, pin_oe_n[31:16]});
  endtask

  task automatic t_low;
    ext_en[15:0] <= 16'h0000;
    wr(IDX_DIR_LOW, 16'hFFFF, 4'hF, RESP_OKAY);
    wr(IDX_EN_LOW, 16'hFFFF, 4'hF, RESP_OKAY);
    wr(IDX_DATA_LOW, 16'h8001, 4'hF, RESP_OKAY);
    rd(IDX_EN_LOW, RESP_OKAY, 32'h0000FFFF);
    rd(IDX_DIR_LOW, RESP_OKAY, 32'h0000FFFF);
    repeat (2) @(posedge aclk);
    chk("low out", 32'h8001, {16'h0, pin_out[15:0]});
    chk("low oe_n", 32'h0000, {16'h0, pin_oe_n[15:0]});
    chk("mid out kept", 32'h3C5A, {16'h0, pin_out[31:16]});
  endtask

  task automatic t_unmapped;
    wr(16'h4410, 16'hFFFF, 4'hF, RESP_SLVERR);
    rd(16'h4410, RESP_SLVERR, 32'h0);
    rd(IDX_DATA_LOW, RESP_OKAY, 32'h00008001);
  endtask

  // Reset in mid-run with pins driven: controls clear, data takes pin level
  task automatic t_rereset;
    ext_en <= '1;
    ext_level <= 32'h5A3CC35A;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("oe_n after second reset", 32'hFFFFFFFF, pin_oe_n);
    chk("high enables", 32'h0, {18'h0, high_pin_enable});
    rd(IDX_EN_LOW, RESP_OKAY, 32'h0);
    rd(IDX_DIR_LOW, RESP_OKAY, 32'h0);
    rd(IDX_EN_MID, RESP_OKAY, 32'h0);
    rd(IDX_DIR_MID, RESP_OKAY, 32'h0);
    rd(IDX_DATA_LOW, RESP_OKAY, 32'h0000C35A);
    rd(IDX_DATA_MID, RESP_OKAY, 32'h00005A3C);
  endtask

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    bus_owned = '0;
    ext_en = '1;
    ext_level = 32'h3C96A5C3;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_regs();
    t_input();
    t_output();
    t_low();
    t_unmapped();
    t_rereset();
    end_sim();
  end
endmodule
